/* File: core/mie_core.v */
// Execution unit for clear, watchdog clear, complement and compare-skip
//
// Overview of operation
// RULE_01: Opcode 0004h clears watchdog count in one cycle
// RULE_02: Watchdog clear zeroes postscaler, sets both status bits
// RULE_03: Complement file into W or back into file
// RULE_04: Access bit picks access bank or banked register
// RULE_05: Indexed literal offset when extended, a=0, f<=5Fh
// RULE_06: Compare-equal subtracts unsigned, leaves flags unchanged
// RULE_07: Equal compare discards next word, two/three cycles
// RULE_08: Clear file writes zero and sets zero flag
// RULE_09: Each cycle: decode, read, process, write phases
`include "mie_defs.vh"

module mie_core #(
  parameter Q_DIV = 1,
  parameter AW    = 12
) (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  output reg         wdt_clear_o,
  output reg         busy_o
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_SKIP1 = 2'd2;
  localparam ST_SKIP2 = 2'd3;

  reg  [1:0]    state;
  reg  [1:0]    phase;
  reg  [7:0]    div_cnt;
  reg           q_en;
  reg  [16:0]   instr;
  reg           ext_en;
  reg  [7:0]    wreg;
  reg  [3:0]    bank_select_reg;
  reg  [AW-1:0] index_reg;
  reg           flag_z;
  reg           flag_n;
  reg           timeout_status_n;
  reg           power_down_status_n;
  reg           skip;
  reg  [7:0]    watchdog_timer;
  reg  [7:0]    wdt_post;
  reg  [AW-1:0] sw_addr;
  reg  [7:0]    cycles;
  reg  [AW-1:0] op_addr;
  reg  [7:0]    result;
  reg           dp_wr;
  reg           rd_pend;
  reg  [11:0]   dp_addr;
  reg  [31:0]   rd_mux;
  reg  [AW-1:0] next_addr;

  wire [7:0]    ram_rdata;
  wire [7:0]    diff     = ram_rdata - wreg; // Unsigned compare difference
  wire          is_wdclr = (instr[15:0] == `MIE_OP_WDCLR);
  wire          is_compl = (instr[15:10] == `MIE_OP_COMPL);
  wire          is_cpfs  = (instr[15:9] == `MIE_OP_CMPEQ);
  wire          is_clear = (instr[15:9] == `MIE_OP_CLEAR);
  wire [7:0]    f_field  = instr[7:0];
  wire          a_bit    = instr[`MIE_BIT_A];
  wire          d_bit    = instr[`MIE_BIT_D];
  wire          idle     = (state == ST_IDLE);
  wire          addr_ph  = hsel_i & hready_i & htrans_i[1];
  wire          sw_wr    = dp_wr & idle;
  wire          go       = sw_wr & (dp_addr == `MIE_OFS_CTRL) & hwdata_i[`MIE_CTRL_GO];
  wire          q4_end   = q_en & (phase == `MIE_Q4);
  wire          exec_wr  = (state == ST_EXEC) & q4_end & (is_clear | (is_compl & d_bit));
  wire          ram_we   = exec_wr | (sw_wr & (dp_addr == `MIE_OFS_MEMDATA));
  wire [AW-1:0] ram_addr = idle ? sw_addr : op_addr;
  wire [7:0]    ram_wd   = idle ? hwdata_i[7:0] : result;

  // Operand address resolution
  always @* begin
    next_addr = {AW{1'b0}};
    // RULE_04: bank select choice
    if (a_bit) begin
      next_addr = {bank_select_reg, f_field};
    // RULE_05: indexed literal offset
    end else if (ext_en && (f_field <= `MIE_ILO_MAX)) begin
      next_addr = index_reg + {{(AW-8){1'b0}}, f_field};
    end else if (f_field <= `MIE_ILO_MAX) begin
      next_addr = {`MIE_BANK_LOW, f_field};
    end else begin
      next_addr = {`MIE_BANK_HIGH, f_field};
    end
  end

  // Phase enable divider
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 8'h00;
      q_en    <= 1'b0;
    end else if (idle) begin
      div_cnt <= 8'h00;
      q_en    <= 1'b0;
    end else if (div_cnt >= Q_DIV[7:0] - 8'h01) begin
      div_cnt <= 8'h00;
      q_en    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      q_en    <= 1'b0;
    end
  end

  // Instruction sequencer
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state  <= ST_IDLE;
      phase  <= `MIE_Q1;
      busy_o <= 1'b0;
      cycles <= 8'h00;
    end else begin
      // RULE_09: four phase cycle
      if (q_en) begin
        phase <= phase + 2'h1;
      end
      case (state)
        ST_IDLE: begin
          phase <= `MIE_Q1;
          if (go) begin
            state  <= ST_EXEC;
            busy_o <= 1'b1;
            cycles <= 8'h00;
          end
        end
        ST_EXEC: begin
          if (q4_end) begin
            cycles <= cycles + 8'h01;
            // RULE_07: skip on equal
            if (skip) begin
              state <= ST_SKIP1;
            end else begin
              state  <= ST_IDLE;
              busy_o <= 1'b0;
            end
          end
        end
        // RULE_07: forced no-operation cycles
        ST_SKIP1: begin
          if (q4_end) begin
            cycles <= cycles + 8'h01;
            if (instr[`MIE_INSTR_TWO]) begin
              state <= ST_SKIP2;
            end else begin
              state  <= ST_IDLE;
              busy_o <= 1'b0;
            end
          end
        end
        default: begin
          if (q4_end) begin
            cycles <= cycles + 8'h01;
            state  <= ST_IDLE;
            busy_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // Datapath phases and software register writes
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      instr               <= 17'h0_0000;
      ext_en              <= 1'b0;
      wreg                <= `MIE_RST_BYTE;
      bank_select_reg     <= 4'h0;
      index_reg           <= {AW{1'b0}};
      flag_z              <= 1'b0;
      flag_n              <= 1'b0;
      timeout_status_n    <= `MIE_RST_FLAGN;
      power_down_status_n <= `MIE_RST_FLAGN;
      skip                <= 1'b0;
      watchdog_timer      <= `MIE_RST_BYTE;
      wdt_post            <= `MIE_RST_BYTE;
      sw_addr             <= {AW{1'b0}};
      op_addr             <= {AW{1'b0}};
      result              <= `MIE_RST_BYTE;
      wdt_clear_o         <= 1'b0;
    end else begin
      wdt_clear_o <= 1'b0;
      if (go) begin
        skip <= 1'b0;
      end
      if (sw_wr) begin
        if (dp_addr == `MIE_OFS_CTRL) begin
          ext_en <= hwdata_i[`MIE_CTRL_EXT];
        end else if (dp_addr == `MIE_OFS_INSTR) begin
          instr <= hwdata_i[16:0];
        end else if (dp_addr == `MIE_OFS_WREG) begin
          wreg <= hwdata_i[7:0];
        end else if (dp_addr == `MIE_OFS_BANK) begin
          bank_select_reg <= hwdata_i[3:0];
        end else if (dp_addr == `MIE_OFS_INDEX) begin
          index_reg <= hwdata_i[AW-1:0];
        end else if (dp_addr == `MIE_OFS_STATUS) begin
          flag_z              <= hwdata_i[`MIE_ST_Z];
          flag_n              <= hwdata_i[`MIE_ST_N];
          power_down_status_n <= hwdata_i[`MIE_ST_PWRDN_N];
          timeout_status_n    <= hwdata_i[`MIE_ST_TMOUT_N];
        end else if (dp_addr == `MIE_OFS_WDOG) begin
          watchdog_timer <= hwdata_i[7:0];
          wdt_post       <= hwdata_i[15:8];
        end else if (dp_addr == `MIE_OFS_MEMADDR) begin
          sw_addr <= hwdata_i[AW-1:0];
        end
      end
      if ((state == ST_EXEC) && q_en) begin
        case (phase)
          // Decode: resolve operand address
          `MIE_Q1: begin
            op_addr <= next_addr;
          end
          // Read: memory is addressed by op_addr from here on
          `MIE_Q2: begin
            result <= result;
          end
          `MIE_Q3: begin
            // RULE_01: watchdog count cleared
            if (is_wdclr) begin
              watchdog_timer <= `MIE_RST_BYTE;
              wdt_clear_o    <= 1'b1;
              // RULE_02: postscaler and status bits
              wdt_post            <= `MIE_RST_BYTE;
              timeout_status_n    <= 1'b1;
              power_down_status_n <= 1'b1;
            end
            // RULE_03: inverse of operand
            if (is_compl) begin
              result <= ~ram_rdata;
            end
            // RULE_08: clear value
            if (is_clear) begin
              result <= `MIE_RST_BYTE;
            end
            // RULE_06: unsigned difference decides skip only
            if (is_cpfs) begin
              skip <= (diff == 8'h00);
            end
          end
          default: begin
            // RULE_03: destination and N, Z flags
            if (is_compl) begin
              flag_z <= (result == 8'h00);
              flag_n <= result[7];
              if (!d_bit) begin
                wreg <= result;
              end
            end
            // RULE_08: zero flag set
            if (is_clear) begin
              flag_z <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Register read multiplexer
  always @* begin
    rd_mux = `MIE_RST_WORD;
    if (dp_addr == `MIE_OFS_CTRL) begin
      rd_mux = {30'h0000_0000, ext_en, busy_o};
    end else if (dp_addr == `MIE_OFS_INSTR) begin
      rd_mux = {15'h0000, instr};
    end else if (dp_addr == `MIE_OFS_WREG) begin
      rd_mux = {24'h00_0000, wreg};
    end else if (dp_addr == `MIE_OFS_BANK) begin
      rd_mux = {28'h000_0000, bank_select_reg};
    end else if (dp_addr == `MIE_OFS_INDEX) begin
      rd_mux = {{(32-AW){1'b0}}, index_reg};
    end else if (dp_addr == `MIE_OFS_STATUS) begin
      rd_mux = {27'h000_0000, skip, timeout_status_n, power_down_status_n, flag_n, flag_z};
    end else if (dp_addr == `MIE_OFS_WDOG) begin
      rd_mux = {16'h0000, wdt_post, watchdog_timer};
    end else if (dp_addr == `MIE_OFS_MEMADDR) begin
      rd_mux = {{(32-AW){1'b0}}, sw_addr};
    end else if (dp_addr == `MIE_OFS_MEMDATA) begin
      rd_mux = {24'h00_0000, ram_rdata};
    end else if (dp_addr == `MIE_OFS_CYCLES) begin
      rd_mux = {24'h00_0000, cycles};
    end
  end

  // Bus slave: zero-wait writes, reads with one wait state
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o    <= `MIE_RST_WORD;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      dp_wr       <= 1'b0;
      rd_pend     <= 1'b0;
      dp_addr     <= 12'h000;
    end else begin
      hresp_o <= 1'b0;
      if (rd_pend) begin
        hrdata_o    <= rd_mux;
        hreadyout_o <= 1'b1;
        rd_pend     <= 1'b0;
        dp_wr       <= 1'b0;
      end else if (addr_ph) begin
        dp_addr     <= haddr_i[11:0];
        dp_wr       <= hwrite_i;
        rd_pend     <= ~hwrite_i;
        hreadyout_o <= hwrite_i;
      end else if (hready_i) begin
        dp_wr <= 1'b0;
      end
    end
  end

  // File register memory
  mie_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .clk_sys_i (clk_sys_i),
    .we_i      (ram_we),
    .addr_i    (ram_addr),
    .wdata_i   (ram_wd),
    .rdata_o   (ram_rdata)
  );

endmodule

/* File: core/mie_defs.vh */
// Constants for the instruction execution block: map, fields, encodings
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH

// Register byte offsets
`define MIE_OFS_CTRL      12'h000
`define MIE_OFS_INSTR     12'h004
`define MIE_OFS_WREG      12'h008
`define MIE_OFS_BANK      12'h00C
`define MIE_OFS_INDEX     12'h010
`define MIE_OFS_STATUS    12'h014
`define MIE_OFS_WDOG      12'h018
`define MIE_OFS_MEMADDR   12'h01C
`define MIE_OFS_MEMDATA   12'h020
`define MIE_OFS_CYCLES    12'h024

// Control register fields
`define MIE_CTRL_GO       0
`define MIE_CTRL_EXT      1
// Instruction register field: next word belongs to a two-word instruction
`define MIE_INSTR_TWO     16

// Status register fields
`define MIE_ST_Z          0
`define MIE_ST_N          1
`define MIE_ST_PWRDN_N    2
`define MIE_ST_TMOUT_N    3
`define MIE_ST_SKIP       4

// Opcode encodings
`define MIE_OP_WDCLR      16'h0004
`define MIE_OP_COMPL      6'h07
`define MIE_OP_CMPEQ      7'h31
`define MIE_OP_CLEAR      7'h35
`define MIE_BIT_D         9
`define MIE_BIT_A         8

// Addressing constants
`define MIE_ILO_MAX       8'h5F
`define MIE_BANK_LOW      4'h0
`define MIE_BANK_HIGH     4'hF

// Reset values
`define MIE_RST_BYTE      8'h00
`define MIE_RST_WORD      32'h0000_0000
`define MIE_RST_FLAGN     1'b1

// Phase codes
`define MIE_Q1            2'h0
`define MIE_Q2            2'h1
`define MIE_Q3            2'h2
`define MIE_Q4            2'h3

`endif

/* File: core/mie_ram.v */
// File register memory with registered read data
module mie_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  input  wire          clk_sys_i,
  input  wire          we_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Synchronous write, read of the current address every cycle
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

/* File: test/mie_core_sva.sv */
// Port-level timing checks for the execution block
module mie_core_chk (
  input wire        clk_sys_i,
  input wire        nrst_i,
  input wire        hsel_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        wdt_clear_o,
  input wire        busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking
    @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // Address phase accepted by the slave
  wire take = hsel_i & hready_i & htrans_i[1];
  chk_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not OKAY");
  chk_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  chk_write_nostall: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  chk_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
    else $error("read data moved");
  chk_wdt_pulse: assert property (wdt_clear_o |=> !wdt_clear_o)
    else $error("watchdog clear pulse too long");
  chk_wdt_phase: assert property (wdt_clear_o |-> busy_o && $past(busy_o, 2))
    else $error("watchdog clear outside process phase");
  chk_busy_min: assert property ($rose(busy_o) |-> busy_o[*4])
    else $error("instruction shorter than four phases");
  chk_busy_max: assert property ($rose(busy_o) |-> ##[4:16] !busy_o)
    else $error("instruction too long");
  // Main scenarios
  cover property (wdt_clear_o);
  cover property ($rose(busy_o) ##[9:16] $fell(busy_o));
  cover property (take && !hwrite_i);
endmodule

/* File: test/test_mcu_instr_exec_clr_com_cmp.sv */
// Random and corner-case bench for the execution block
`include "mie_defs.vh"
module test_mcu_instr_exec_clr_com_cmp;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 0;
  logic        nrst_i    = 0;
  logic        hsel_i    = 0;
  logic [31:0] haddr_i   = 0;
  logic [1:0]  htrans_i  = 0;
  logic        hwrite_i  = 0;
  logic [31:0] hwdata_i  = 0;
  wire  [31:0] hrdata_o;
  wire         hreadyout_o;
  wire         hresp_o;
  wire         wdt_clear_o;
  wire         busy_o;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          clear_pulses = 0;
  logic [31:0] r;
  logic [11:0] ea, ix;
  logic [7:0]  v, w, f, res;
  logic [15:0] op;
  logic [3:0]  bk, st;
  logic        a, d, x, two;

  // Device under test
  mie_core uut (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (3'h2),
    .hwdata_i    (hwdata_i),
    .hready_i    (hreadyout_o),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .wdt_clear_o (wdt_clear_o),
    .busy_o      (busy_o)
  );

  // Clock at 200 MHz
  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  // Counts watchdog clear strobes seen on the output
  always @(posedge clk_sys_i) begin
    if (wdt_clear_o === 1'b1)
      clear_pulses <= clear_pulses + 1;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for hready high at a rising edge, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        $display("ERROR %0t bus hang", $time);
        conclude();
      end
      @(posedge clk_sys_i);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in r
  task automatic ahb(input logic wr, input logic [11:0] ad, input logic [31:0] dt);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {20'h0_0000, ad};
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'h0;
    hwdata_i <= dt;
    wait_ready();
    r = hrdata_o;
  endtask

  task automatic go(input logic [15:0] o, input logic t, input logic e);
    ahb(1, `MIE_OFS_INSTR, {15'h0000, t, o});
    ahb(1, `MIE_OFS_CTRL, {30'h0000_0000, e, 1'b1});
  endtask

  // Polls the busy bit, bounded
  task automatic wait_idle;
    int n;
    for (n = 0; n < 30; n++) begin
      ahb(0, `MIE_OFS_CTRL, 0);
      if (r[0] === 1'b0)
        return;
    end
    bad_count++;
    $display("ERROR %0t still busy", $time);
    conclude();
  endtask

  // Operand address resolution
  function automatic logic [11:0] eaddr(logic a, logic x, logic [3:0] b, logic [7:0] f,
                                        logic [11:0] ix);
    if (a)
      return {b, f};
    if (x && f <= 8'h5F)
      return ix + {4'h0, f};
    return {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
  endfunction

  // Main sequence
  initial begin
    void'($urandom(32'hee9c0377));
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    ahb(0, `MIE_OFS_STATUS, 0);
    chk(r[15:0], 16'h000C);
    ahb(1, 12'h030, 32'hFFFF_FFFF);
    ahb(0, 12'h030, 0);
    chk(r[15:0], 16'h0000);
    ahb(1, `MIE_OFS_WDOG, $urandom | 32'h0000_0101);
    ahb(1, `MIE_OFS_STATUS, 0);
    ahb(1, `MIE_OFS_WREG, 32'h0000_003C);
    go(16'h0004, 1'b0, 1'b0);
    ahb(1, `MIE_OFS_WREG, 32'h0000_00A5);
    wait_idle();
    ahb(0, `MIE_OFS_WDOG, 0);
    chk(r[15:0], 16'h0000);
    ahb(0, `MIE_OFS_STATUS, 0);
    chk(r[15:0], 16'h000C);
    chk(16'(clear_pulses), 16'h0001);
    ahb(0, `MIE_OFS_WREG, 0);
    chk(r[15:0], 16'h003C);
    for (int i = 0; i < 60; i++) begin
      {a, d, x, two, bk, st} = $urandom;
      {w, v, ix} = $urandom;
      f = (i % 4 == 0) ? 8'h5F + 8'((i >> 2) & 1) : 8'($urandom);
      if (i % 2)
        v = w;
      ea = eaddr(a, x, bk, f, ix);
      op = (i % 3 == 0) ? {6'h07, d, a, f} : (i % 3 == 1) ? {7'h35, a, f} : {7'h31, a, f};
      res = ~v;
      ahb(1, `MIE_OFS_BANK, 32'(bk));
      ahb(1, `MIE_OFS_INDEX, 32'(ix));
      ahb(1, `MIE_OFS_WREG, 32'(w));
      ahb(1, `MIE_OFS_STATUS, 32'(st));
      ahb(1, `MIE_OFS_MEMADDR, 32'(ea));
      ahb(1, `MIE_OFS_MEMDATA, 32'(v));
      go(op, two, x);
      wait_idle();
      ahb(0, `MIE_OFS_MEMDATA, 0);
      chk(r[15:0], 16'(i % 3 == 1 ? 8'h00 : (i % 3 == 0 && d) ? res : v));
      ahb(0, `MIE_OFS_WREG, 0);
      chk(r[15:0], 16'(i % 3 == 0 && !d ? res : w));
      ahb(0, `MIE_OFS_STATUS, 0);
      chk(r[15:0], 16'(i % 3 == 0 ? {1'b0, st[3:2], res[7], res == 8'h00} :
                       i % 3 == 1 ? {1'b0, st[3:1], 1'b1} : {v == w, st}));
      ahb(0, `MIE_OFS_CYCLES, 0);
      chk(r[15:0], 16'(i % 3 == 2 && v == w ? (two ? 3 : 2) : 1));
    end
    chk(16'(clear_pulses), 16'h0001);
    conclude();
  end
endmodule

bind mie_core mie_core_chk chk (
  .clk_sys_i   (clk_sys_i),
  .nrst_i      (nrst_i),
  .hsel_i      (hsel_i),
  .htrans_i    (htrans_i),
  .hwrite_i    (hwrite_i),
  .hready_i    (hready_i),
  .hrdata_o    (hrdata_o),
  .hreadyout_o (hreadyout_o),
  .hresp_o     (hresp_o),
  .wdt_clear_o (wdt_clear_o),
  .busy_o      (busy_o)
);
